/* File: verilog/lcd_drive_pkg.sv */
// Constants, level codes and carrier structs for the segment display driver.
// Assumes one 250 MHz clock; every slower rate arrives as a one-cycle tick.
package lcd_drive_pkg;

   // Clock of the whole block
   localparam int CLK_PERIOD_NS = 4;

   // Pin and memory geometry
   localparam int NUM_COM_PINS  = 4;
   localparam int NUM_SHR_PINS  = 4;
   localparam int NUM_SEG_PINS  = 30;
   localparam int NUM_PINS      = NUM_COM_PINS + NUM_SHR_PINS + NUM_SEG_PINS;
   localparam int LAST_SEG      = 33;
   localparam int RAM_BYTES     = 68;
   localparam int AREA_BYTES    = 34;
   localparam int LINE_STEPS    = 16;
   localparam int FOUR_COM_DUTY = 3;

   // Drive level codes: ground, then the four bias rails in rising order
   typedef logic [2:0] level_type;
   localparam level_type LVL_GND  = 3'h0;
   localparam level_type LVL_ONE  = 3'h1;
   localparam level_type LVL_TWO  = 3'h2;
   localparam level_type LVL_THR  = 3'h3;
   localparam level_type LVL_FOUR = 3'h4;

   // Values after reset
   localparam logic [7:0] RAM_RESET    = 8'h00;
   localparam logic [6:0] DIV_RESET    = 7'h00;
   localparam logic [7:0] STEP_RESET   = 8'h00;
   localparam logic [2:0] COM_RESET    = 3'h0;
   localparam logic [2:0] LINE_RESET   = 3'h0;
   localparam logic [4:0] CONTR_RESET  = 5'h00;

   typedef enum logic [1:0] {
      DISP_OFF,
      DISP_NORMAL,
      DISP_ALL_ON,
      DISP_ALL_OFF
   } display_mode_type;

   // Operating clock control
   typedef struct packed {
      logic [1:0] clock_source_select;
      logic [2:0] clock_divider_select;
      logic       debug_run_enable;
      logic       module_enable_bit;
      logic       sleep_clock_stop;
   } clock_ctrl_type;

   // Display configuration
   typedef struct packed {
      logic [2:0]       drive_duty_select;
      logic [3:0]       frame_divider_count;
      logic [2:0]       nline_select;
      logic             bias_quarter;
      logic [4:0]       contrast_level;
      display_mode_type display_mode;
      logic             display_inverse;
      logic             common_reverse;
      logic             segment_reverse;
      logic             display_area;
      logic [7:0]       partial_common_mask;
   } display_cfg_type;

   // Display memory access port
   typedef struct packed {
      logic       write_en;
      logic [6:0] addr;
      logic [7:0] wdata;
   } ram_access_type;

endpackage

/* File: verilog/drive_level_cell.sv */
// One output pin of the panel driver: turns role, state and polarity into a level.
// Assumes the caller supplies all inputs from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none
module drive_level_cell
   import lcd_drive_pkg::*;
(
   input  wire logic      clk,
   input  wire logic      nrst,
   input  wire logic      role_com,
   input  wire logic      active,
   input  wire logic      pol,
   input  wire logic      quarter,
   input  wire logic      blank,
   output level_type      level_ff
);

   level_type nxt_level;
   level_type full_lvl;

   // Waveform table; an off segment sits one bias step from an idle common
   always_comb begin
      full_lvl = quarter ? LVL_FOUR : LVL_THR;
      if (blank) begin
         nxt_level = LVL_GND;
      end else if (role_com) begin
         if (active) begin
            nxt_level = pol ? full_lvl : LVL_GND;
         end else begin
            nxt_level = pol ? LVL_ONE : (quarter ? LVL_THR : LVL_TWO);
         end
      end else begin
         if (active) begin
            nxt_level = pol ? LVL_GND : full_lvl;
         end else begin
            nxt_level = quarter ? LVL_TWO : (pol ? LVL_TWO : LVL_ONE);
         end
      end
   end

   // Registered so pins never glitch while role or data settles
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         level_ff <= LVL_GND;
      end else begin
         level_ff <= nxt_level;
      end
   end

endmodule
`default_nettype wire

/* File: verilog/lcd_segment_driver_core.sv */
// Segment display driver core: display memory, frame timing and pin levels.
// Assumes source ticks, debug and sleep status come from logic on clk.
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Debug with run bit low stops clock
// - Stopped in debug: blank, keep state
// - Debug with run bit high keeps running
// - Shared pins commons above four-common duty
// - Display memory of 68 bytes
// - One-third and one-quarter bias drive
// - Sixteen frame rate steps by division
// - Contrast has 32 levels
// - All-on, all-off and inverse modes
// - Segment and common order reversible
// - Partial common drive by mask
// - Polarity inverts every n lines
// - Interrupt request once per frame
// - Frame is 16*(count+1)*(duty+1) ticks
// - Flag cleared by writing one
module lcd_segment_driver_core
   import lcd_drive_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    nrst,
   input  wire logic [3:0]              source_ticks,
   input  wire logic                    debug_mode,
   input  wire logic                    sleep_mode,
   input  wire clock_ctrl_type          clk_ctrl,
   input  wire display_cfg_type         cfg,
   input  wire ram_access_type          ram_access,
   input  wire logic                    frame_interrupt_enable,
   input  wire logic                    frame_flag_clear,
   output logic [7:0]                   ram_rdata_ff,
   output logic                         frame_interrupt_flag,
   output logic                         frame_irq,
   output logic                         shared_is_common_ff,
   output logic                         driver_running_ff,
   output logic                         bias_quarter_ff,
   output logic [4:0]                   contrast_code_ff,
   output level_type [NUM_COM_PINS-1:0] common_pins,
   output level_type [NUM_SHR_PINS-1:0] shared_common_segment_pins,
   output level_type [NUM_SEG_PINS-1:0] segment_pins
);

   logic [7:0]            disp_ram_ff [RAM_BYTES];
   logic [6:0]            div_cnt_ff;
   logic [6:0]            nxt_div_cnt;
   logic [7:0]            step_cnt_ff;
   logic [7:0]            nxt_step_cnt;
   logic [2:0]            com_idx_ff;
   logic [2:0]            nxt_com_idx;
   logic [2:0]            line_cnt_ff;
   logic [2:0]            nxt_line_cnt;
   logic                  frame_pol_ff;
   logic                  nxt_frame_pol;
   logic                  line_pol_ff;
   logic                  nxt_line_pol;
   logic                  flag_ff;
   logic                  nxt_flag;
   logic                  frame_end;
   logic                  nxt_running;
   logic [6:0]            div_mask;
   logic                  src_tick;
   logic                  debug_hold;
   logic                  sleep_hold;
   logic                  clock_run;
   logic                  driver_operating_clock;
   logic [7:0]            step_limit;
   logic                  eight_com;
   logic                  blank;
   logic [NUM_PINS-1:0]   pin_role_com;
   logic [NUM_PINS-1:0]   pin_active;
   level_type [NUM_PINS-1:0] pin_level;

   // Operating clock: picked source tick, divided by a power of two
   always_comb begin
      src_tick   = source_ticks[clk_ctrl.clock_source_select];
      div_mask   = 7'((8'h01 << clk_ctrl.clock_divider_select) - 8'h01);
      debug_hold = debug_mode && !clk_ctrl.debug_run_enable;
      sleep_hold = sleep_mode && clk_ctrl.sleep_clock_stop;
      clock_run  = clk_ctrl.module_enable_bit && !debug_hold && !sleep_hold;
      driver_operating_clock = clock_run && src_tick && ((div_cnt_ff & div_mask) == div_mask);
      step_limit = 8'((9'(cfg.frame_divider_count) + 9'h001) * 9'(LINE_STEPS) - 9'h001);
      eight_com  = cfg.drive_duty_select > 3'(FOUR_COM_DUTY);
      // A stopped clock leaves a DC level on the glass, so blank the pins
      blank      = !clock_run || (cfg.display_mode == DISP_OFF);
   end

   // Timing counters; a debug or sleep stop freezes them so state survives debug
   always_comb begin
      nxt_div_cnt   = div_cnt_ff;
      nxt_step_cnt  = step_cnt_ff;
      nxt_com_idx   = com_idx_ff;
      nxt_line_cnt  = line_cnt_ff;
      nxt_frame_pol = frame_pol_ff;
      nxt_line_pol  = line_pol_ff;
      frame_end     = 1'b0;
      nxt_running   = clock_run;
      if (!clk_ctrl.module_enable_bit) begin
         nxt_div_cnt   = DIV_RESET;
         nxt_step_cnt  = STEP_RESET;
         nxt_com_idx   = COM_RESET;
         nxt_line_cnt  = LINE_RESET;
         nxt_frame_pol = 1'b0;
         nxt_line_pol  = 1'b0;
      end else if (clock_run && src_tick) begin
         nxt_div_cnt = driver_operating_clock ? DIV_RESET : 7'(div_cnt_ff + 7'h01);
         if (driver_operating_clock) begin
            if (step_cnt_ff >= step_limit) begin
               nxt_step_cnt = STEP_RESET;
               // Line-wise inversion spreads DC error across the frame
               if (cfg.nline_select != 3'h0) begin
                  if (3'(line_cnt_ff + 3'h1) >= cfg.nline_select) begin
                     nxt_line_cnt = LINE_RESET;
                     nxt_line_pol = !line_pol_ff;
                  end else begin
                     nxt_line_cnt = 3'(line_cnt_ff + 3'h1);
                  end
               end else begin
                  nxt_line_cnt = LINE_RESET;
                  nxt_line_pol = 1'b0;
               end
               if (com_idx_ff >= cfg.drive_duty_select) begin
                  nxt_com_idx   = COM_RESET;
                  nxt_frame_pol = !frame_pol_ff;
                  frame_end     = 1'b1;
               end else begin
                  nxt_com_idx = 3'(com_idx_ff + 3'h1);
               end
            end else begin
               nxt_step_cnt = 8'(step_cnt_ff + 8'h01);
            end
         end
      end
      // Set wins over a clear written in the same cycle
      if (frame_end) begin
         nxt_flag = 1'b1;
      end else if (frame_flag_clear) begin
         nxt_flag = 1'b0;
      end else begin
         nxt_flag = flag_ff;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         div_cnt_ff          <= DIV_RESET;
         step_cnt_ff         <= STEP_RESET;
         com_idx_ff          <= COM_RESET;
         line_cnt_ff         <= LINE_RESET;
         frame_pol_ff        <= 1'b0;
         line_pol_ff         <= 1'b0;
         flag_ff             <= 1'b0;
         driver_running_ff   <= 1'b0;
         shared_is_common_ff <= 1'b0;
         bias_quarter_ff     <= 1'b0;
         contrast_code_ff    <= CONTR_RESET;
      end else begin
         div_cnt_ff          <= nxt_div_cnt;
         step_cnt_ff         <= nxt_step_cnt;
         com_idx_ff          <= nxt_com_idx;
         line_cnt_ff         <= nxt_line_cnt;
         frame_pol_ff        <= nxt_frame_pol;
         line_pol_ff         <= nxt_line_pol;
         flag_ff             <= nxt_flag;
         driver_running_ff   <= nxt_running;
         shared_is_common_ff <= eight_com;
         bias_quarter_ff     <= cfg.bias_quarter;
         contrast_code_ff    <= cfg.contrast_level;
      end
   end

   // Request only while both flag and enable are set
   assign frame_interrupt_flag = flag_ff;
   assign frame_irq            = flag_ff && frame_interrupt_enable;

   // Display memory; writes past the last byte are dropped, reads give zero
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i < RAM_BYTES; i++) begin
            disp_ram_ff[i] <= RAM_RESET;
         end
         ram_rdata_ff <= RAM_RESET;
      end else begin
         if (ram_access.write_en && (ram_access.addr < 7'(RAM_BYTES))) begin
            disp_ram_ff[ram_access.addr] <= ram_access.wdata;
         end
         ram_rdata_ff <= (ram_access.addr < 7'(RAM_BYTES)) ? disp_ram_ff[ram_access.addr] : 8'h00;
      end
   end

   // Per-pin role and on/off decode; pins 0-7 may be commons, 4-37 segments
   always_comb begin
      logic [2:0] k;
      logic [2:0] logical;
      logic [5:0] sp;
      logic [5:0] seg_lo;
      logic [5:0] ridx;
      logic [6:0] byte_idx;
      logic       dot;
      k        = 3'h0;
      logical  = 3'h0;
      sp       = 6'h00;
      seg_lo   = eight_com ? 6'h04 : 6'h00;
      ridx     = 6'h00;
      byte_idx = 7'h00;
      dot      = 1'b0;
      for (int j = 0; j < NUM_PINS; j++) begin
         pin_role_com[j] = (j < NUM_COM_PINS) ||
                           ((j < NUM_COM_PINS + NUM_SHR_PINS) && eight_com);
         if (pin_role_com[j]) begin
            k       = 3'(j);
            logical = cfg.common_reverse ? 3'(cfg.drive_duty_select - k) : k;
            pin_active[j] = (k <= cfg.drive_duty_select) && (logical == com_idx_ff) &&
                            cfg.partial_common_mask[k];
         end else begin
            sp   = 6'(j - NUM_COM_PINS);
            ridx = cfg.segment_reverse ? 6'(seg_lo + 6'(LAST_SEG) - sp) : sp;
            byte_idx = 7'(ridx) + (cfg.display_area ? 7'(AREA_BYTES) : 7'h00);
            dot  = disp_ram_ff[byte_idx][com_idx_ff];
            case (cfg.display_mode)
               DISP_ALL_ON:  dot = 1'b1;
               DISP_ALL_OFF: dot = 1'b0;
               default:      dot = dot;
            endcase
            pin_active[j] = dot ^ cfg.display_inverse;
         end
      end
   end

   // One level cell per pin
   genvar g;
   generate
      for (g = 0; g < NUM_PINS; g++) begin : pin_gen
         drive_level_cell u_cell (
            .clk      (clk),
            .nrst     (nrst),
            .role_com (pin_role_com[g]),
            .active   (pin_active[g]),
            .pol      (frame_pol_ff ^ line_pol_ff),
            .quarter  (cfg.bias_quarter),
            .blank    (blank),
            .level_ff (pin_level[g])
         );
      end
   endgenerate

   assign common_pins                = pin_level[NUM_COM_PINS-1:0];
   assign shared_common_segment_pins = pin_level[NUM_COM_PINS+NUM_SHR_PINS-1:NUM_COM_PINS];
   assign segment_pins               = pin_level[NUM_PINS-1:NUM_COM_PINS+NUM_SHR_PINS];

endmodule
`default_nettype wire

/* File: dv/lcd_core_properties.sv */
// Port checker for the segment display driver core.
// Assumes it is bound to the core; one clock, asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module lcd_core_properties
   import lcd_drive_pkg::*;
(
   input wire logic                         clk,
   input wire logic                         nrst,
   input wire logic                         debug_mode,
   input wire logic                         sleep_mode,
   input wire clock_ctrl_type               clk_ctrl,
   input wire display_cfg_type              cfg,
   input wire ram_access_type               ram_access,
   input wire logic                         frame_interrupt_enable,
   input wire logic                         frame_flag_clear,
   input wire logic [7:0]                   ram_rdata_ff,
   input wire logic                         frame_interrupt_flag,
   input wire logic                         frame_irq,
   input wire logic                         shared_is_common_ff,
   input wire logic                         driver_running_ff,
   input wire logic                         bias_quarter_ff,
   input wire logic [4:0]                   contrast_code_ff,
   input wire level_type [NUM_COM_PINS-1:0] common_pins,
   input wire level_type [NUM_SHR_PINS-1:0] shared_common_segment_pins,
   input wire level_type [NUM_SEG_PINS-1:0] segment_pins
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);
   // Debug hold and its blanked outputs, one registered cycle late
   sequence s_hold; debug_mode && !clk_ctrl.debug_run_enable; endsequence
   sequence s_runs;
      debug_mode && clk_ctrl.debug_run_enable && clk_ctrl.module_enable_bit && !sleep_mode;
   endsequence
   sequence s_blank;
      common_pins == '0 && shared_common_segment_pins == '0 && segment_pins == '0;
   endsequence
   property p_stop; s_hold |=> !driver_running_ff; endproperty
   property p_blank; s_hold |=> s_blank; endproperty
   property p_run; s_runs |=> driver_running_ff; endproperty
   property p_irq; frame_irq == (frame_interrupt_flag && frame_interrupt_enable); endproperty
   property p_clear; $fell(frame_interrupt_flag) |-> $past(frame_flag_clear); endproperty
   property p_sticky; frame_interrupt_flag && !frame_flag_clear |=> frame_interrupt_flag;
   endproperty
   property p_shared; 1'b1 |=> shared_is_common_ff == ($past(cfg.drive_duty_select) > 3'h3);
   endproperty
   property p_bias; 1'b1 |=> bias_quarter_ff == $past(cfg.bias_quarter); endproperty
   property p_contr; 1'b1 |=> contrast_code_ff == $past(cfg.contrast_level); endproperty
   property p_ram; ram_access.addr >= 7'h44 |=> ram_rdata_ff == 8'h00; endproperty
   a_stop: assert property (p_stop) else $error("clock not stopped in debug");
   a_blank: assert property (p_blank) else $error("pins not blank in debug");
   a_run: assert property (p_run) else $error("clock stopped with run bit");
   a_irq: assert property (p_irq) else $error("request not flag and enable");
   a_clear: assert property (p_clear) else $error("flag fell without clear");
   a_sticky: assert property (p_sticky) else $error("flag lost");
   a_shared: assert property (p_shared) else $error("shared pin role wrong");
   a_bias: assert property (p_bias) else $error("bias copy wrong");
   a_contr: assert property (p_contr) else $error("contrast copy wrong");
   a_ram: assert property (p_ram) else $error("read beyond memory not zero");
endmodule
`default_nettype wire

/* File: dv/panel_glass_model.sv */
// Panel glass stand-in: judges the level codes the driver puts on it.
// Assumes level codes settle on the driver clock; no timing of its own.
`timescale 1ns/1ps
`default_nettype none
module panel_glass_model
   import lcd_drive_pkg::*;
(
   input  wire level_type [NUM_COM_PINS-1:0] com,
   input  wire level_type [NUM_SHR_PINS-1:0] shr,
   input  wire level_type [NUM_SEG_PINS-1:0] seg,
   output logic                             biased,
   output logic                             bad_level
);
   level_type [NUM_PINS-1:0] pins;
   assign pins = {com, shr, seg};
   // Any rail above ground biases the glass; codes past the top rail cannot exist
   always_comb begin
      biased    = 1'b0;
      bad_level = 1'b0;
      for (int i = 0; i < NUM_PINS; i++) begin
         biased    = biased | (pins[i] != LVL_GND);
         bad_level = bad_level | (pins[i] > LVL_FOUR);
      end
   end
endmodule
`default_nettype wire

/* File: dv/tb_lcd_segment_driver_core.sv */
// Self-checking bench for the display driver core with a panel stand-in.
// Assumes the checker bound below; ticks from sources are driven every cycle in the frame cases, single ticks in the pin cases.
`timescale 1ns/1ps
`default_nettype none
module tb_lcd_segment_driver_core
   import lcd_drive_pkg::*;
;
   logic                         clk = 1'b0;
   logic                         nrst = 1'b0;
   logic [3:0]                   source_ticks = 4'h0;
   logic                         debug_mode = 1'b0;
   logic                         sleep_mode = 1'b0;
   clock_ctrl_type               clk_ctrl = '0;
   display_cfg_type              cfg = '0;
   ram_access_type               ram_access = '0;
   logic                         frame_interrupt_enable = 1'b0;
   logic                         frame_flag_clear = 1'b0;
   logic [7:0]                   ram_rdata_ff;
   logic                         frame_interrupt_flag, frame_irq, shared_is_common_ff;
   logic                         driver_running_ff, bias_quarter_ff, biased, bad_level;
   logic [4:0]                   contrast_code_ff;
   level_type [NUM_COM_PINS-1:0] common_pins;
   level_type [NUM_SHR_PINS-1:0] shared_common_segment_pins;
   level_type [NUM_SEG_PINS-1:0] segment_pins;
   int                           num_errors = 0, compares = 0, cyc = 0, t0, t1, t2;
   int                           mem [RAM_BYTES];
   int                           dt [5] = '{0, 1, 7, 3, 2};
   int                           ft [5] = '{0, 1, 0, 15, 0};
   int                           nt [5] = '{0, 0, 1, 0, 3};

   always #2 clk = ~clk;
   always @(posedge clk) cyc <= cyc + 1;

   lcd_segment_driver_core dut_u (.clk, .nrst, .source_ticks, .debug_mode, .sleep_mode,
      .clk_ctrl, .cfg, .ram_access, .frame_interrupt_enable, .frame_flag_clear,
      .ram_rdata_ff, .frame_interrupt_flag, .frame_irq, .shared_is_common_ff,
      .driver_running_ff, .bias_quarter_ff, .contrast_code_ff, .common_pins,
      .shared_common_segment_pins, .segment_pins);
   // Glass is wired to the pins from time zero, before any enable
   panel_glass_model panel_u (.com(common_pins), .shr(shared_common_segment_pins),
      .seg(segment_pins), .biased, .bad_level);

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic finish_test;
      if (num_errors == 0 && compares > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task automatic cyc_wait(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // Bounded wait for a frame flag; optional write-1 clear afterwards
   task automatic wait_flag(output int t, input bit clr);
      t = -1;
      for (int i = 0; i < 9000 && t < 0; i++) begin
         cyc_wait(1);
         if (frame_interrupt_flag === 1'b1) t = cyc;
      end
      if (clr) begin
         @(posedge clk) frame_flag_clear <= 1'b1;
         @(posedge clk) frame_flag_clear <= 1'b0;
      end
   endtask
   // Frame spacing; the first two frames after enable are skipped and the third is timed
   task automatic frame_case(input int d, input int f, input int n, input int s);
      @(posedge clk) clk_ctrl.module_enable_bit <= 1'b0;
      source_ticks <= 4'($urandom) | (4'h1 << s);
      clk_ctrl.clock_source_select <= s[1:0];
      clk_ctrl.clock_divider_select <= n[2:0];
      cfg.drive_duty_select <= d[2:0];
      cfg.frame_divider_count <= f[3:0];
      @(posedge clk) clk_ctrl.module_enable_bit <= 1'b1;
      wait_flag(t0, 1'b1);
      wait_flag(t1, 1'b1);
      wait_flag(t2, 1'b1);
      chk(t2 - t1, 16 * (f + 1) * (d + 1) * (1 << n));
   endtask
   // Restart with the sources quiet, then step whole lines by single ticks so the
   // common index and polarity are known; one common and one segment pin are judged
   task automatic pin_case(input int lines);
      int   c, p, d, s, b, full, e0, e1;
      logic on;
      @(posedge clk) clk_ctrl.module_enable_bit <= 1'b0;
      source_ticks <= 4'h0;
      clk_ctrl.clock_divider_select <= 3'h0;
      cfg.frame_divider_count <= 4'h0;
      cfg.drive_duty_select <= 3'($urandom);
      cfg.bias_quarter <= 1'($urandom);
      @(posedge clk) clk_ctrl.module_enable_bit <= 1'b1;
      repeat (LINE_STEPS * lines) begin
         @(posedge clk) source_ticks <= 4'hf;
         @(posedge clk) source_ticks <= 4'h0;
      end
      cyc_wait(2);
      d = cfg.drive_duty_select;
      c = lines % (d + 1);
      p = (lines / (d + 1) + (cfg.nline_select == 0 ? 0 : lines / cfg.nline_select)) % 2;
      s = $urandom % NUM_SEG_PINS + 4;
      b = (cfg.segment_reverse ? (d > FOUR_COM_DUTY ? 4 : 0) + LAST_SEG - s : s) +
          (cfg.display_area ? AREA_BYTES : 0);
      full = cfg.bias_quarter ? 4 : 3;
      on = cfg.display_mode == DISP_ALL_ON || (cfg.display_mode == DISP_NORMAL && mem[b][c]);
      on = on ^ cfg.display_inverse;
      e0 = p ? 1 : full - 1;
      if (cfg.partial_common_mask[0] && ((cfg.common_reverse ? d : 0) == c)) begin
         e0 = p ? full : 0;
      end
      e1 = on ? (p ? 0 : full) : (cfg.bias_quarter ? 2 : (p ? 2 : 1));
      if (cfg.display_mode == DISP_OFF) begin
         e0 = 0;
         e1 = 0;
      end
      chk(common_pins[0], e0);
      chk(segment_pins[s - 4], e1);
   endtask

   initial begin
      #200000;
      num_errors++;
      finish_test;
   end

   initial begin
      void'($urandom(32'h5fd644ff));
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      cyc_wait(1);
      chk(frame_interrupt_flag, 0);
      chk(ram_rdata_ff, 0);
      // Fill memory, including writes past its end that must vanish
      for (int a = 0; a < 128; a++) begin
         @(posedge clk) ram_access <= {1'b1, a[6:0], 8'($urandom)};
         #1 if (a < RAM_BYTES) mem[a] = ram_access.wdata;
      end
      @(posedge clk) ram_access.write_en <= 1'b0;
      for (int k = 0; k < 5; k++) frame_case(dt[k], ft[k], nt[k], k % 4);
      frame_case($urandom % 8, $urandom % 16, 0, 1);
      // Request follows flag only while enabled
      wait_flag(t0, 1'b0);
      chk(frame_irq, 0);
      @(posedge clk) frame_interrupt_enable <= 1'b1;
      cyc_wait(1);
      chk(frame_irq, 1);
      frame_case(0, 0, 0, 2);
      // Debug hold: clock stops, glass blank, no frames until release
      @(posedge clk) debug_mode <= 1'b1;
      clk_ctrl.debug_run_enable <= 1'b0;
      cyc_wait(3);
      chk(driver_running_ff, 0);
      chk(biased, 0);
      @(posedge clk) frame_flag_clear <= 1'b1;
      @(posedge clk) frame_flag_clear <= 1'b0;
      cyc_wait(100);
      chk(frame_interrupt_flag, 0);
      @(posedge clk) debug_mode <= 1'b0;
      wait_flag(t0, 1'b1);
      chk(t0 > 0, 1);
      @(posedge clk) debug_mode <= 1'b1;
      clk_ctrl.debug_run_enable <= 1'b1;
      cyc_wait(3);
      chk(driver_running_ff, 1);
      wait_flag(t0, 1'b1);
      chk(t0 > 0, 1);
      @(posedge clk) debug_mode <= 1'b0;
      sleep_mode <= 1'b1;
      clk_ctrl.sleep_clock_stop <= 1'b0;
      cyc_wait(3);
      chk(driver_running_ff, 1);
      @(posedge clk) clk_ctrl.sleep_clock_stop <= 1'b1;
      cyc_wait(3);
      chk(driver_running_ff, 0);
      chk(biased, 0);
      @(posedge clk) sleep_mode <= 1'b0;
      // Memory survives the debug hold; past its end reads zero
      for (int a = 0; a < 128; a++) begin
         @(posedge clk) ram_access <= {1'b0, a[6:0], 8'h00};
         cyc_wait(1);
         chk(ram_rdata_ff, a < RAM_BYTES ? mem[a] : 0);
      end
      // Pin role by duty, supply copies
      for (int d = 0; d < 8; d++) begin
         @(posedge clk) cfg.drive_duty_select <= d[2:0];
         cfg.contrast_level <= 5'($urandom);
         cfg.bias_quarter <= d[0];
         cyc_wait(2);
         chk(shared_is_common_ff, d > 3);
         chk(bias_quarter_ff, d[0]);
         chk(contrast_code_ff, cfg.contrast_level);
      end
      // Every mode with inverse, reversal, partial commons and n-line drive
      for (int m = 0; m < 8; m++) begin
         @(posedge clk) cfg.display_mode <= display_mode_type'(m[1:0]);
         cfg.display_inverse <= m[2];
         cfg.nline_select <= 3'($urandom);
         cfg.partial_common_mask <= 8'($urandom);
         cfg.common_reverse <= m[0];
         cfg.segment_reverse <= m[1];
         cfg.display_area <= m[2];
         cyc_wait(40);
         chk(bad_level, 0);
         pin_case($urandom % 24);
      end
      finish_test;
   end
endmodule

bind lcd_segment_driver_core lcd_core_properties chk_u (.clk, .nrst, .debug_mode,
   .sleep_mode, .clk_ctrl, .cfg, .ram_access, .frame_interrupt_enable, .frame_flag_clear,
   .ram_rdata_ff, .frame_interrupt_flag, .frame_irq, .shared_is_common_ff,
   .driver_running_ff, .bias_quarter_ff, .contrast_code_ff, .common_pins,
   .shared_common_segment_pins, .segment_pins);
`default_nettype wire
